// ===== verilog/slk_defs.svh
`ifndef SLK_DEFS_SVH
`define SLK_DEFS_SVH

`define SLK_CLK_HZ       50000000
`define SLK_BIT_RATE_HZ  10000000
// clock cycles per link bit
`define SLK_BIT_CYC      (`SLK_CLK_HZ / `SLK_BIT_RATE_HZ)
`define SLK_TIM_W        3
`define SLK_BIT_RELOAD   3'(`SLK_BIT_CYC - 1)
// from start edge to the centre of the second bit
`define SLK_FIRST_WAIT   3'(`SLK_BIT_CYC + (`SLK_BIT_CYC / 2) - 1)
`define SLK_LAST_DATA    4'h7
`define SLK_CNT_W        4
`define SLK_FRAME_W      11
`define SLK_DATA_LEN     4'hb
`define SLK_ACK_LEN      4'h2
`define SLK_ACK_FRAME    11'h001
`define SLK_DATA_HEAD    2'h3
`define SLK_STOP_BIT     1'h0
`define SLK_IDLE_LEVEL   1'h0

`endif

// ===== verilog/slk_pkg.sv
package slk_pkg;

   typedef logic [7:0] slk_byte_type;

   typedef enum logic [1:0] {
      RX_IDLE = 2'h0,
      RX_KIND = 2'h1,
      RX_DATA = 2'h3,
      RX_STOP = 2'h2
   } slk_rx_state_type;

endpackage

// ===== verilog/slk_link_if.sv
`timescale 1ns/1ps

interface slk_link_if;
   logic to_peer;
   logic to_node;

   modport node (
      output to_peer,
      input  to_node
   );

   modport peer (
      input  to_peer,
      output to_node
   );
endinterface

// ===== verilog/slk_node.sv
`timescale 1ns/1ps
`include "slk_defs.svh"
// Behaviour
// - one outgoing, one incoming line per node
// - data frame: start, one, eight bits, stop
// - acknowledge frame: start then a zero
// - next byte only after acknowledge received
// - single byte buffer; acknowledge needs room
// - acknowledge early when data reception starts
// - frames interleaved, data sent back to back
// - message done after last byte acknowledged
// - standard link bit rate, clock independent
// - phase-insensitive receiver, resync every frame
// - data bits least significant first
// - multibyte values low byte first
module slk_node
   import slk_pkg::*;
(
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   slk_link_if.node          link,
   input  wire slk_byte_type tx_data_i,
   input  wire logic         tx_valid_i,
   input  wire logic         tx_last_i,
   output logic              tx_ready_o,
   output logic              msg_done_o,
   output slk_byte_type      rx_data_o,
   output logic              rx_valid_o,
   input  wire logic         rx_ready_i
);

   logic                        line_s1_q;
   logic                        line_s2_q;
   logic                        line_s3_q;
   logic                        start_edge;
   slk_rx_state_type            rx_state_q;
   logic [`SLK_TIM_W-1:0]       rx_tim_q;
   logic [`SLK_CNT_W-1:0]       rx_cnt_q;
   slk_byte_type                rx_sh_q;
   logic                        rx_tick;
   logic                        hdr_data;
   logic                        hdr_ack;
   logic                        byte_end;
   slk_byte_type                buf_q;
   logic                        buf_full_q;
   logic                        hold_q;
   logic                        owed_q;
   logic                        take;
   logic                        ack_req;
   logic [`SLK_FRAME_W-1:0]     frame_q;
   logic [`SLK_CNT_W-1:0]       left_q;
   logic [`SLK_TIM_W-1:0]       tx_tim_q;
   logic                        credit_q;
   logic                        ack_pend_q;
   logic                        last_out_q;
   logic                        slot;
   logic                        load_ack;
   logic                        load_data;

   // incoming line comes from the far node's clock, so it is synchronised first
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         line_s1_q <= `SLK_IDLE_LEVEL;
         line_s2_q <= `SLK_IDLE_LEVEL;
         line_s3_q <= `SLK_IDLE_LEVEL;
      end else begin
         line_s1_q <= link.to_node;
         line_s2_q <= line_s1_q;
         line_s3_q <= line_s2_q;
      end
   end

   assign start_edge = line_s2_q & ~line_s3_q;
   assign rx_tick    = (rx_tim_q == '0);

   // timing restarts on every start edge, so clock phase never matters
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rx_state_q <= RX_IDLE;
         rx_tim_q   <= '0;
         rx_cnt_q   <= '0;
         rx_sh_q    <= '0;
      end else begin
         unique case (rx_state_q)
            RX_IDLE: begin
               if (start_edge) begin
                  rx_state_q <= RX_KIND;
                  rx_tim_q   <= `SLK_FIRST_WAIT;
               end
            end
            RX_KIND: begin
               if (rx_tick) begin
                  rx_tim_q   <= `SLK_BIT_RELOAD;
                  rx_cnt_q   <= '0;
                  rx_state_q <= line_s2_q ? RX_DATA : RX_IDLE;
               end else begin
                  rx_tim_q <= rx_tim_q - 1'b1;
               end
            end
            RX_DATA: begin
               if (rx_tick) begin
                  rx_sh_q  <= {line_s2_q, rx_sh_q[7:1]};
                  rx_tim_q <= `SLK_BIT_RELOAD;
                  rx_cnt_q <= rx_cnt_q + 1'b1;
                  if (rx_cnt_q == `SLK_LAST_DATA) begin
                     rx_state_q <= RX_STOP;
                  end
               end else begin
                  rx_tim_q <= rx_tim_q - 1'b1;
               end
            end
            RX_STOP: begin
               if (rx_tick) begin
                  rx_state_q <= RX_IDLE;
               end else begin
                  rx_tim_q <= rx_tim_q - 1'b1;
               end
            end
         endcase
      end
   end

   assign hdr_data = (rx_state_q == RX_KIND) & rx_tick & line_s2_q;
   assign hdr_ack  = (rx_state_q == RX_KIND) & rx_tick & ~line_s2_q;
   assign byte_end = (rx_state_q == RX_STOP) & rx_tick;
   assign take     = buf_full_q & rx_ready_i;

   // the shift register doubles as the spare place while the buffer is full
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         buf_q      <= '0;
         buf_full_q <= 1'b0;
         hold_q     <= 1'b0;
      end else if (byte_end && (!buf_full_q || take)) begin
         buf_q      <= rx_sh_q;
         buf_full_q <= 1'b1;
      end else if (byte_end) begin
         hold_q <= 1'b1;
      end else if (take && hold_q) begin
         buf_q  <= rx_sh_q;
         hold_q <= 1'b0;
      end else if (take) begin
         buf_full_q <= 1'b0;
      end
   end

   // early acknowledge while the buffer is free, else wait for the consumer
   assign ack_req = (hdr_data & (~buf_full_q | take)) | (owed_q & take);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         owed_q <= 1'b0;
      end else if (hdr_data && buf_full_q && !take) begin
         owed_q <= 1'b1;
      end else if (take) begin
         owed_q <= 1'b0;
      end
   end

   assign rx_data_o  = buf_q;
   assign rx_valid_o = buf_full_q;

   // a new frame may start in the cycle the last bit of the previous one ends
   assign slot       = (left_q == '0) | ((tx_tim_q == '0) & (left_q == `SLK_CNT_W'(1)));
   assign load_ack   = slot & ack_pend_q;
   assign load_data  = slot & ~ack_pend_q & credit_q & tx_valid_i;
   assign tx_ready_o = slot & ~ack_pend_q & credit_q;

   // acknowledges go first so the far sender waits on our data only while one of our frames is already on the line
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         frame_q  <= '0;
         left_q   <= '0;
         tx_tim_q <= '0;
      end else if (load_ack) begin
         frame_q  <= `SLK_ACK_FRAME;
         left_q   <= `SLK_ACK_LEN;
         tx_tim_q <= `SLK_BIT_RELOAD;
      end else if (load_data) begin
         frame_q  <= {`SLK_STOP_BIT, tx_data_i, `SLK_DATA_HEAD};
         left_q   <= `SLK_DATA_LEN;
         tx_tim_q <= `SLK_BIT_RELOAD;
      end else if ((left_q != '0) && (tx_tim_q == '0)) begin
         frame_q  <= {`SLK_IDLE_LEVEL, frame_q[`SLK_FRAME_W-1:1]};
         left_q   <= left_q - 1'b1;
         tx_tim_q <= `SLK_BIT_RELOAD;
      end else if (left_q != '0) begin
         tx_tim_q <= tx_tim_q - 1'b1;
      end
   end

   // zeros shift in behind each frame, so the line idles low
   assign link.to_peer = frame_q[0];

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ack_pend_q <= 1'b0;
      end else begin
         ack_pend_q <= ack_req | (ack_pend_q & ~load_ack);
      end
   end

   // an arriving acknowledge wins over the send that uses up the credit
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         credit_q <= 1'b1;
      end else begin
         if (load_data) begin
            credit_q <= 1'b0;
         end
         if (hdr_ack) begin
            credit_q <= 1'b1;
         end
      end
   end

   // bytes of a message are fed in low byte first by the user side
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         last_out_q <= 1'b0;
         msg_done_o <= 1'b0;
      end else begin
         if (load_data) begin
            last_out_q <= tx_last_i;
         end
         msg_done_o <= hdr_ack & ~credit_q & last_out_q;
      end
   end

endmodule

// ===== verilog/slk_peer.sv
`timescale 1ns/1ps
`include "slk_defs.svh"
// far end: acknowledges only once a whole byte has found room
module slk_peer
   import slk_pkg::*;
(
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   slk_link_if.peer          link,
   input  wire slk_byte_type tx_data_i,
   input  wire logic         tx_valid_i,
   output logic              tx_ready_o,
   output logic              tx_done_o,
   output slk_byte_type      rx_data_o,
   output logic              rx_valid_o,
   input  wire logic         rx_ready_i
);

   logic                        s1_q;
   logic                        s2_q;
   logic                        s3_q;
   slk_rx_state_type            rx_state_q;
   logic [`SLK_TIM_W-1:0]       rx_tim_q;
   logic [`SLK_CNT_W-1:0]       rx_cnt_q;
   slk_byte_type                rx_sh_q;
   logic                        rx_tick;
   logic                        hdr_ack;
   logic                        byte_end;
   slk_byte_type                buf_q;
   logic                        buf_full_q;
   logic                        hold_q;
   logic                        take;
   logic                        ack_req;
   logic [`SLK_FRAME_W-1:0]     frame_q;
   logic [`SLK_CNT_W-1:0]       left_q;
   logic [`SLK_TIM_W-1:0]       tx_tim_q;
   logic                        credit_q;
   logic                        ack_pend_q;
   logic                        slot;
   logic                        load_ack;
   logic                        load_data;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s1_q <= `SLK_IDLE_LEVEL;
         s2_q <= `SLK_IDLE_LEVEL;
         s3_q <= `SLK_IDLE_LEVEL;
      end else begin
         s1_q <= link.to_peer;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign rx_tick = (rx_tim_q == '0);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rx_state_q <= RX_IDLE;
         rx_tim_q   <= '0;
         rx_cnt_q   <= '0;
         rx_sh_q    <= '0;
      end else begin
         unique case (rx_state_q)
            RX_IDLE: begin
               if (s2_q && !s3_q) begin
                  rx_state_q <= RX_KIND;
                  rx_tim_q   <= `SLK_FIRST_WAIT;
               end
            end
            RX_KIND: begin
               if (rx_tick) begin
                  rx_tim_q   <= `SLK_BIT_RELOAD;
                  rx_cnt_q   <= '0;
                  rx_state_q <= s2_q ? RX_DATA : RX_IDLE;
               end else begin
                  rx_tim_q <= rx_tim_q - 1'b1;
               end
            end
            RX_DATA: begin
               if (rx_tick) begin
                  rx_sh_q  <= {s2_q, rx_sh_q[7:1]};
                  rx_tim_q <= `SLK_BIT_RELOAD;
                  rx_cnt_q <= rx_cnt_q + 1'b1;
                  if (rx_cnt_q == `SLK_LAST_DATA) begin
                     rx_state_q <= RX_STOP;
                  end
               end else begin
                  rx_tim_q <= rx_tim_q - 1'b1;
               end
            end
            RX_STOP: begin
               if (rx_tick) begin
                  rx_state_q <= RX_IDLE;
               end else begin
                  rx_tim_q <= rx_tim_q - 1'b1;
               end
            end
         endcase
      end
   end

   assign hdr_ack  = (rx_state_q == RX_KIND) & rx_tick & ~s2_q;
   assign byte_end = (rx_state_q == RX_STOP) & rx_tick;
   assign take     = buf_full_q & rx_ready_i;
   // slower than an early acknowledge, and still uses the shift register as the spare place
   assign ack_req  = (byte_end & (~buf_full_q | take)) | (take & hold_q);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         buf_q      <= '0;
         buf_full_q <= 1'b0;
         hold_q     <= 1'b0;
      end else if (byte_end && (!buf_full_q || take)) begin
         buf_q      <= rx_sh_q;
         buf_full_q <= 1'b1;
      end else if (byte_end) begin
         hold_q <= 1'b1;
      end else if (take && hold_q) begin
         buf_q  <= rx_sh_q;
         hold_q <= 1'b0;
      end else if (take) begin
         buf_full_q <= 1'b0;
      end
   end

   assign rx_data_o  = buf_q;
   assign rx_valid_o = buf_full_q;

   assign slot       = (left_q == '0) | ((tx_tim_q == '0) & (left_q == `SLK_CNT_W'(1)));
   assign load_ack   = slot & ack_pend_q;
   assign load_data  = slot & ~ack_pend_q & credit_q & tx_valid_i;
   assign tx_ready_o = slot & ~ack_pend_q & credit_q;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         frame_q  <= '0;
         left_q   <= '0;
         tx_tim_q <= '0;
      end else if (load_ack) begin
         frame_q  <= `SLK_ACK_FRAME;
         left_q   <= `SLK_ACK_LEN;
         tx_tim_q <= `SLK_BIT_RELOAD;
      end else if (load_data) begin
         frame_q  <= {`SLK_STOP_BIT, tx_data_i, `SLK_DATA_HEAD};
         left_q   <= `SLK_DATA_LEN;
         tx_tim_q <= `SLK_BIT_RELOAD;
      end else if ((left_q != '0) && (tx_tim_q == '0)) begin
         frame_q  <= {`SLK_IDLE_LEVEL, frame_q[`SLK_FRAME_W-1:1]};
         left_q   <= left_q - 1'b1;
         tx_tim_q <= `SLK_BIT_RELOAD;
      end else if (left_q != '0) begin
         tx_tim_q <= tx_tim_q - 1'b1;
      end
   end

   assign link.to_node = frame_q[0];

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ack_pend_q <= 1'b0;
         credit_q   <= 1'b1;
         tx_done_o  <= 1'b0;
      end else begin
         ack_pend_q <= ack_req | (ack_pend_q & ~load_ack);
         if (load_data) begin
            credit_q <= 1'b0;
         end
         if (hdr_ack) begin
            credit_q <= 1'b1;
         end
         tx_done_o <= hdr_ack & ~credit_q;
      end
   end

endmodule

// ===== sim/slk_link_sva.sv
`timescale 1ns/1ps
module slk_link_sva (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic to_peer,
   input wire logic to_node
);
   logic [1:0] ln, ln_q, act_q, kind_q, start, dec;
   logic [2:0] cyc_q  [2];
   logic [3:0] bit_q  [2];
   logic [1:0] cred_q [2];
   logic [1:0] cap_q  [2];
   assign ln = {to_node, to_peer};
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         start[i] = ln[i] && !ln_q[i] && !act_q[i];
         dec[i]   = act_q[i] && (bit_q[i] == 4'h1) && (cyc_q[i] == 3'h0);
      end
   end
   // bit position of the current sample on each line
   always_ff @(posedge ref_clk_i) begin
      for (int i = 0; i < 2; i++) begin
         if (rst_i) begin
            ln_q[i]  <= 1'b0;
            act_q[i] <= 1'b0;
            cyc_q[i] <= 3'h0;
            bit_q[i] <= 4'h0;
         end else begin
            ln_q[i] <= ln[i];
            if (start[i]) begin
               act_q[i] <= 1'b1;
               cyc_q[i] <= 3'h1;
               bit_q[i] <= 4'h0;
            end else if (act_q[i]) begin
               if (dec[i]) begin
                  kind_q[i] <= ln[i];
               end
               if (cyc_q[i] == 3'h4) begin
                  cyc_q[i] <= 3'h0;
                  bit_q[i] <= bit_q[i] + 4'h1;
                  if ((bit_q[i] == 4'h1 && !kind_q[i]) || bit_q[i] == 4'ha) begin
                     act_q[i] <= 1'b0;
                  end
               end else begin
                  cyc_q[i] <= cyc_q[i] + 3'h1;
               end
            end
         end
      end
   end
   // credit is captured at the start edge, so a late ack cannot excuse it
   always_ff @(posedge ref_clk_i) begin
      for (int i = 0; i < 2; i++) begin
         if (rst_i) begin
            cred_q[i] <= 2'h1;
            cap_q[i]  <= 2'h1;
         end else begin
            cred_q[i] <= cred_q[i] + 2'(dec[i ^ 1] && !ln[i ^ 1]) - 2'(dec[i] && ln[i]);
            if (start[i]) begin
               cap_q[i] <= cred_q[i];
            end
         end
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence data_s; start[0] ##5 to_peer; endsequence
   sequence ack_s; start[0] ##5 !to_peer; endsequence
   start_peer_a: assert property (start[0] |-> to_peer [*5])
      else $error("start bit on node line not five cycles");
   start_node_a: assert property (start[1] |-> to_node [*5])
      else $error("start bit on peer line not five cycles");
   stable_peer_a: assert property (act_q[0] && cyc_q[0] != 3'h0 |-> $stable(to_peer))
      else $error("node line changed inside a bit");
   stable_node_a: assert property (act_q[1] && cyc_q[1] != 3'h0 |-> $stable(to_node))
      else $error("peer line changed inside a bit");
   frame_len_a: assert property (data_s |-> ##45 !to_peer [*5])
      else $error("data frame stop bit misplaced");
   ack_bit_a: assert property (ack_s |-> !to_peer [*5])
      else $error("ack second bit not low");
   ack_node_a: assert property (start[1] ##5 !to_node |-> !to_node [*5])
      else $error("peer ack second bit not low");
   stop_node_a: assert property (act_q[1] && bit_q[1] == 4'ha |-> !to_node)
      else $error("peer stop bit high");
   credit_node_a: assert property (dec[0] && to_peer |-> cap_q[0] != 2'h0)
      else $error("node sent data without ack");
   credit_peer_a: assert property (dec[1] && to_node |-> cap_q[1] != 2'h0)
      else $error("peer sent data without ack");
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
   import slk_pkg::*;
   localparam logic [23:0] MSG = 24'h813ca5;
   logic         ref_clk, peer_clk, rst;
   slk_byte_type n_txd, n_rxd, p_txd, p_rxd;
   logic         n_txv, n_last, n_txr, n_done, n_rxv, n_rxr;
   logic         p_txv, p_txr, p_done, p_rxv, p_rxr;
   int           bad_count, checks, done_cnt, tdone_cnt, n_cnt, p_cnt, cyc, rx_at_done;
   slk_byte_type pq[$], nq[$], dq[2][$];
   int           ds[2][$], as_q[2][$];
   logic [1:0]   lines;
   slk_link_if slk_link_if_i ();
   assign lines = {slk_link_if_i.to_node, slk_link_if_i.to_peer};
   slk_node slk_node_i (.ref_clk_i(ref_clk), .rst_i(rst), .link(slk_link_if_i),
      .tx_data_i(n_txd), .tx_valid_i(n_txv), .tx_last_i(n_last), .tx_ready_o(n_txr),
      .msg_done_o(n_done), .rx_data_o(n_rxd), .rx_valid_o(n_rxv), .rx_ready_i(n_rxr));
   slk_peer slk_peer_i (.ref_clk_i(peer_clk), .rst_i(rst), .link(slk_link_if_i),
      .tx_data_i(p_txd), .tx_valid_i(p_txv), .tx_ready_o(p_txr), .tx_done_o(p_done),
      .rx_data_o(p_rxd), .rx_valid_o(p_rxv), .rx_ready_i(p_rxr));
   slk_link_sva slk_link_sva_i (.ref_clk_i(ref_clk), .rst_i(rst),
      .to_peer(slk_link_if_i.to_peer), .to_node(slk_link_if_i.to_node));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // peer clock lags by 7 ns so the receivers see foreign phase
   initial begin
      peer_clk = 1'b0;
      #7;
      forever #10 peer_clk = ~peer_clk;
   end
   always @(posedge ref_clk) cyc <= cyc + 1;
   // settle after the negedge drivers so ready pairs with its own take edge
   always @(negedge ref_clk) begin
      #1;
      if (p_rxv === 1'b1 && p_rxr) begin
         pq.push_back(p_rxd);
         p_cnt++;
      end
      if (n_rxv === 1'b1 && n_rxr) begin
         nq.push_back(n_rxd);
         n_cnt++;
      end
      if (n_done === 1'b1) begin
         done_cnt++;
         rx_at_done = p_cnt;
      end
      if (p_done === 1'b1) tdone_cnt++;
   end
   task automatic chk(input slk_byte_type seen, input slk_byte_type exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (bad_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wait_cnt(ref int c, input int want);
      int n;
      n = 0;
      while (c < want && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      chk(8'(c), 8'(want));
   endtask
   // valid is left high so a following call can keep frames back to back
   task automatic node_send(input slk_byte_type d, input logic last);
      int n;
      n = 0;
      n_txd = d;
      n_txv = 1'b1;
      n_last = last;
      while (n_txr !== 1'b1 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      chk(8'(n < 3000), 8'h1);
      @(negedge ref_clk);
   endtask
   task automatic peer_send(input slk_byte_type d);
      int n;
      n = 0;
      p_txd = d;
      p_txv = 1'b1;
      while (p_txr !== 1'b1 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      chk(8'(n < 3000), 8'h1);
      @(negedge ref_clk);
   endtask
   // wire decoder: idle low, high start, then kind bit
   task automatic mon(input int w);
      slk_byte_type b;
      int t0;
      forever begin
         @(negedge ref_clk iff lines[w] === 1'b1);
         t0 = cyc;
         repeat (5) @(negedge ref_clk);
         if (lines[w]) begin
            for (int k = 0; k < 8; k++) begin
               repeat (5) @(negedge ref_clk);
               b[k] = lines[w];
            end
            repeat (5) @(negedge ref_clk);
            chk(8'(lines[w]), 8'h0);
            dq[w].push_back(b);
            ds[w].push_back(t0);
         end else begin
            as_q[w].push_back(t0);
         end
      end
   endtask
   initial begin
      rst = 1'b1;
      n_txd = 8'h00;
      n_txv = 1'b0;
      n_last = 1'b0;
      n_rxr = 1'b0;
      p_txd = 8'h00;
      p_txv = 1'b0;
      p_rxr = 1'b1;
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      fork
         mon(0);
         mon(1);
      join_none
      for (int k = 0; k < 3; k++) begin
         chk(8'(done_cnt), 8'h0);
         node_send(MSG[8*k +: 8], k == 2);
      end
      n_txv = 1'b0;
      wait_cnt(done_cnt, 1);
      chk(8'(rx_at_done), 8'h3);
      for (int k = 0; k < 3; k++) begin
         chk(pq[k], MSG[8*k +: 8]);
         chk(dq[0][k], MSG[8*k +: 8]);
      end
      peer_send(8'h5a);
      peer_send(8'hc3);
      p_txv = 1'b0;
      repeat (150) @(negedge ref_clk);
      chk(8'(tdone_cnt), 8'h1);
      chk(8'(n_rxv), 8'h1);
      chk(n_rxd, 8'h5a);
      chk(8'(ds[1][1] - ds[1][0]), 8'h37);
      chk(8'(as_q[0][0] - ds[1][0] < 20), 8'h1);
      n_rxr = 1'b1;
      wait_cnt(n_cnt, 2);
      wait_cnt(tdone_cnt, 2);
      chk(nq[0], 8'h5a);
      chk(nq[1], 8'hc3);
      fork
         begin
            node_send(8'h00, 1'b0);
            node_send(8'hff, 1'b1);
            n_txv = 1'b0;
         end
         begin
            peer_send(8'h80);
            peer_send(8'h7f);
            p_txv = 1'b0;
         end
      join
      wait_cnt(done_cnt, 2);
      wait_cnt(n_cnt, 4);
      wait_cnt(p_cnt, 5);
      wait_cnt(tdone_cnt, 4);
      chk(pq[3], 8'h00);
      chk(pq[4], 8'hff);
      chk(nq[2], 8'h80);
      chk(nq[3], 8'h7f);
      conclude();
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      bad_count++;
      conclude();
   end
endmodule
